// ==== common/pcio_pkg.sv ====
`default_nettype none
package pcio_pkg;
  localparam int ADDR_W = 29;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int NUM_AREAS = 5;
  localparam int LARGEST_AREA = 4;
  localparam int FIFO_DEPTH = 4;
  // Core clock 250 MHz; I/O reference 32 MHz nominal, cycle clock 16 MHz
  localparam int CLK_MHZ = 250;
  localparam int IO_REF_MHZ = 32;
  localparam int CYC_MHZ = 16;
  localparam int REF_DIV = 2;
  // Area select from address bits
  localparam int AREA_LSB = 24;
  localparam int AREA_W = 3;
  localparam int TYPE_LSB = 19;
  localparam int TYPE_W = 2;
  // Cycle lengths in 16 MHz ticks per cycle type
  localparam logic [3:0] LEN_T0 = 4'h3;
  localparam logic [3:0] LEN_T1 = 4'h4;
  localparam logic [3:0] LEN_T2 = 4'h6;
  localparam logic [3:0] LEN_T3 = 4'h8;
  localparam logic [1:0] TYPE_RESET = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOW   = 3'b001,
    ST_WAIT  = 3'b011,
    ST_HIGH  = 3'b010,
    ST_DONE  = 3'b110
  } bus_state_t;
  typedef struct packed {
    logic                write;
    logic                wide;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } req_t;
endpackage : pcio_pkg
`default_nettype wire

// ==== common/req_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface req_if;
  logic               valid;
  logic               ready;
  pcio_pkg::req_t     data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : req_if
`default_nettype wire

// ==== logic/pc_io_bus.sv ====
`timescale 1ns/1ns
`default_nettype none
module pc_io_bus (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          io_reference_clock,
  // Processor request
  input  wire logic                          cpu_valid,
  output logic                               cpu_ready,
  input  wire logic                          cpu_write,
  input  wire logic [31:0]                   cpu_addr,
  input  wire logic [pcio_pkg::DATA_W-1:0]   cpu_wdata,
  input  wire logic                          cpu_wide,
  // Processor answer
  output logic                               rsp_valid,
  output logic [pcio_pkg::DATA_W-1:0]        rsp_rdata,
  // External bus
  output logic [pcio_pkg::ADDR_W-1:0]        exported_address_bus,
  output logic [pcio_pkg::NUM_AREAS-1:0]     cs_n,
  output logic                               io_read_strobe,
  output logic                               io_write_strobe,
  input  wire logic [pcio_pkg::HALF_W-1:0]   io_data_in,
  output logic [pcio_pkg::HALF_W-1:0]        io_data_out,
  output logic                               io_data_oe,
  input  wire logic                          ready_pin,
  // Extension latch control
  output logic                               ext_latch_rd,
  output logic                               ext_drive_wr,
  input  wire logic                          mux_latch_in,
  input  wire logic                          mux_half_in
);
  req_if q_in ();
  req_if q_out ();

  typedef struct packed {
    pcio_pkg::bus_state_t              state;
    logic [2:0]                        ref_s;
    logic [2:0]                        rdy_s;
    logic [2:0]                        lat_s;
    logic [2:0]                        hlf_s;
    logic                              ref_q;
    logic                              ref_l;
    logic                              rdy_q;
    logic                              lat_q;
    logic                              hlf_q;
    logic                              div;
    logic [3:0]                        len;
    logic [3:0]                        cnt;
    logic                              write;
    logic                              wide;
    logic [pcio_pkg::ADDR_W-1:0]       addr;
    logic [pcio_pkg::DATA_W-1:0]       wdata;
    logic [pcio_pkg::HALF_W-1:0]       rhi;
    logic [pcio_pkg::NUM_AREAS-1:0]    cs_n;
    logic                              rd_n;
    logic                              wr_n;
    logic [pcio_pkg::HALF_W-1:0]       dout;
    logic                              oe;
    logic                              ext_rd;
    logic                              ext_wr;
    logic                              rsp_v;
    logic [pcio_pkg::DATA_W-1:0]       rdata;
    logic                              phase2;
  } st_t;
  st_t st_r;
  st_t st_nxt;

  logic       tick;
  logic [2:0] area;
  logic [1:0] ctype;
  logic [3:0] clen;

  req_fifo #(
    .WIDTH ($bits(pcio_pkg::req_t)),
    .DEPTH (pcio_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (q_in),
    .rd  (q_out)
  );

  assign q_in.valid      = cpu_valid;
  assign q_in.data.write = cpu_write;
  assign q_in.data.wide  = cpu_wide;
  assign q_in.data.addr  = cpu_addr[pcio_pkg::ADDR_W-1:0];
  assign q_in.data.wdata = cpu_wdata;
  assign cpu_ready       = q_in.ready;
  assign q_out.ready     = (st_r.state == pcio_pkg::ST_IDLE);

  // Reference edge halved to the 16 MHz cycle tick
  assign tick = st_r.ref_q && st_r.div;

  // Area and cycle type decode
  assign area  = q_out.data.addr[pcio_pkg::AREA_LSB +: pcio_pkg::AREA_W];
  assign ctype = q_out.data.addr[pcio_pkg::TYPE_LSB +: pcio_pkg::TYPE_W];
  always_comb begin
    logic [1:0] t;
    t = ctype;
    if (area == 3'(pcio_pkg::LARGEST_AREA)) begin
      t = {1'b0, ctype[0]};
    end
    case (t)
      2'h0:    clen = pcio_pkg::LEN_T0;
      2'h1:    clen = pcio_pkg::LEN_T1;
      2'h2:    clen = pcio_pkg::LEN_T2;
      2'h3:    clen = pcio_pkg::LEN_T3;
      default: clen = pcio_pkg::LEN_T0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ref_s = {st_r.ref_s[1:0], io_reference_clock};
    st_nxt.rdy_s = {st_r.rdy_s[1:0], ready_pin};
    st_nxt.lat_s = {st_r.lat_s[1:0], mux_latch_in};
    st_nxt.hlf_s = {st_r.hlf_s[1:0], mux_half_in};
    st_nxt.ref_q = 1'b0;
    if (st_r.ref_s[2] == st_r.ref_s[1]) begin
      st_nxt.ref_l = st_r.ref_s[2];
      if (st_r.ref_s[2] && !st_r.ref_l) begin
        st_nxt.ref_q = 1'b1;
      end
    end
    if (st_r.rdy_s[2] == st_r.rdy_s[1]) begin
      st_nxt.rdy_q = st_r.rdy_s[2];
    end
    if (st_r.lat_s[2] == st_r.lat_s[1]) begin
      st_nxt.lat_q = st_r.lat_s[2];
    end
    if (st_r.hlf_s[2] == st_r.hlf_s[1]) begin
      st_nxt.hlf_q = st_r.hlf_s[2];
    end
    if (st_r.ref_q) begin
      st_nxt.div = ~st_r.div;
    end
    st_nxt.rsp_v = 1'b0;
    case (st_r.state)
      pcio_pkg::ST_IDLE: begin
        if (q_out.valid) begin
          st_nxt.write  = q_out.data.write;
          st_nxt.wide   = q_out.data.wide;
          st_nxt.addr   = q_out.data.addr;
          st_nxt.wdata  = q_out.data.wdata;
          st_nxt.len    = clen;
          st_nxt.cnt    = '0;
          st_nxt.phase2 = 1'b0;
          st_nxt.state  = pcio_pkg::ST_LOW;
        end
      end
      pcio_pkg::ST_LOW: begin
        if (tick) begin
          st_nxt.cs_n = '1;
          if (st_r.addr[pcio_pkg::AREA_LSB +: pcio_pkg::AREA_W]
              < 3'(pcio_pkg::NUM_AREAS)) begin
            st_nxt.cs_n[st_r.addr[pcio_pkg::AREA_LSB +: pcio_pkg::AREA_W]]
              = 1'b0;
          end
          st_nxt.rd_n = st_r.write;
          st_nxt.wr_n = ~st_r.write;
          st_nxt.oe   = st_r.write;
          st_nxt.dout = st_r.phase2
                        ? st_r.wdata[31:16] : st_r.wdata[15:0];
          st_nxt.ext_wr = st_r.write && st_r.wide && !st_r.hlf_q;
          st_nxt.cnt   = 4'h1;
          st_nxt.state = pcio_pkg::ST_WAIT;
        end
      end
      pcio_pkg::ST_WAIT: begin
        if (tick) begin
          if (st_r.cnt < st_r.len) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (st_r.rdy_q) begin
            st_nxt.state = pcio_pkg::ST_HIGH;
          end
        end
      end
      pcio_pkg::ST_HIGH: begin
        st_nxt.cs_n = '1;
        st_nxt.rd_n = 1'b1;
        st_nxt.wr_n = 1'b1;
        st_nxt.oe   = 1'b0;
        st_nxt.ext_wr = 1'b0;
        st_nxt.ext_rd = 1'b0;
        if (!st_r.write) begin
          if (st_r.phase2 || (st_r.wide && st_r.lat_q)) begin
            st_nxt.rhi = io_data_in;
          end
          if (!st_r.phase2) begin
            st_nxt.rdata[15:0] = io_data_in;
          end
          st_nxt.ext_rd = st_r.wide && !st_r.lat_q && !st_r.hlf_q
                          && !st_r.phase2;
        end
        st_nxt.state = pcio_pkg::ST_DONE;
      end
      pcio_pkg::ST_DONE: begin
        st_nxt.ext_rd = 1'b0;
        if (st_r.wide && st_r.hlf_q && !st_r.phase2) begin
          st_nxt.phase2 = 1'b1;
          st_nxt.state  = pcio_pkg::ST_LOW;
        end else begin
          // Upper half from bus on a wide access when latched or on the second phase, else zero
          st_nxt.rdata[31:16] = (st_r.wide && (st_r.lat_q || st_r.phase2))
                                ? st_r.rhi : 16'h0000;
          st_nxt.rsp_v = 1'b1;
          st_nxt.state = pcio_pkg::ST_IDLE;
        end
      end
      default: st_nxt.state = pcio_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.state <= pcio_pkg::ST_IDLE;
      st_r.cs_n  <= '1;
      st_r.rd_n  <= 1'b1;
      st_r.wr_n  <= 1'b1;
      st_r.rdy_q <= 1'b1;
      st_r.rdy_s <= 3'b111;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign exported_address_bus = st_r.addr;
  assign cs_n                 = st_r.cs_n;
  assign io_read_strobe       = st_r.rd_n;
  assign io_write_strobe      = st_r.wr_n;
  assign io_data_out          = st_r.dout;
  assign io_data_oe           = st_r.oe;
  assign ext_latch_rd         = st_r.ext_rd;
  assign ext_drive_wr         = st_r.ext_wr;
  assign rsp_valid            = st_r.rsp_v;
  assign rsp_rdata            = st_r.rdata;

  a_strobe_excl: assert property (@(posedge clk) disable iff (rst)
    !(!st_r.rd_n && !st_r.wr_n))
    else $error("both strobes low");
  a_cs_onehot: assert property (@(posedge clk) disable iff (rst)
    $countones(~st_r.cs_n) <= 1)
    else $error("two selects");
  a_cs_strobe: assert property (@(posedge clk) disable iff (rst)
    (st_r.cs_n != '1) |-> (st_r.rd_n != st_r.wr_n))
    else $error("select without strobe");
  a_dir_match: assert property (@(posedge clk) disable iff (rst)
    (!st_r.wr_n) |-> st_r.write)
    else $error("write strobe on read");
  a_release_tog: assert property (@(posedge clk) disable iff (rst)
    $rose(&st_r.cs_n) |-> (st_r.rd_n && st_r.wr_n))
    else $error("strobe outlives select");
  a_wait_ready: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == pcio_pkg::ST_WAIT && !st_r.rdy_q) |=>
    (st_r.state == pcio_pkg::ST_WAIT))
    else $error("ready ignored");
  a_len_min: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == pcio_pkg::ST_WAIT && $past(st_r.state) ==
    pcio_pkg::ST_WAIT && st_nxt.state == pcio_pkg::ST_HIGH) |->
    (st_r.cnt == st_r.len))
    else $error("cycle too short");
  a_big_area: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == pcio_pkg::ST_WAIT && st_r.addr[pcio_pkg::AREA_LSB +:
    pcio_pkg::AREA_W] == 3'(pcio_pkg::LARGEST_AREA)) |->
    (st_r.len <= pcio_pkg::LEN_T1))
    else $error("bad type in area");
  a_oe_write: assert property (@(posedge clk) disable iff (rst)
    st_r.oe |-> !st_r.wr_n)
    else $error("drive outside write");
  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    (!st_r.rd_n || !st_r.wr_n) |=> $stable(st_r.addr))
    else $error("address moved in cycle");
  a_ext_pulse: assert property (@(posedge clk) disable iff (rst)
    st_r.ext_rd |=> !st_r.ext_rd)
    else $error("latch pulse too long");
  a_phase_wide: assert property (@(posedge clk) disable iff (rst)
    st_r.phase2 |-> st_r.wide)
    else $error("second phase on narrow");
  a_cnt_bound: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == pcio_pkg::ST_WAIT) |-> (st_r.cnt <= st_r.len))
    else $error("count past length");
  c_read: cover property (@(posedge clk) $fell(st_r.rd_n));
  c_write: cover property (@(posedge clk) $fell(st_r.wr_n));
  c_stall: cover property (@(posedge clk)
    st_r.state == pcio_pkg::ST_WAIT && !st_r.rdy_q);
  c_two_phase: cover property (@(posedge clk) $rose(st_r.phase2));
  c_long_cycle: cover property (@(posedge clk)
    st_r.state == pcio_pkg::ST_WAIT && st_r.len == pcio_pkg::LEN_T3);
endmodule : pc_io_bus
`default_nettype wire

// ==== logic/req_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module req_fifo #(
  parameter int WIDTH = $bits(pcio_pkg::req_t),
  parameter int DEPTH = pcio_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Fill side
  req_if.snk        wr,
  // Drain side
  req_if.src        rd
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } fifo_st_t;
  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;
  assign wr.ready = (st_r.cnt != (PW+1)'(DEPTH));
  assign rd.valid = (st_r.cnt != '0);
  assign rd.data  = mem_r[st_r.rp];
  assign push = wr.valid && wr.ready;
  assign pop  = rd.valid && rd.ready;
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem_r[st_r.wp] <= wr.data;
    end
  end
  a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    st_r.cnt <= (PW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : req_fifo
`default_nettype wire

// ==== logic/unused_placeholder_none.sv ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== test/io_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module io_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Device bus
  input  wire logic [4:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [28:0] addr,
  input  wire logic [15:0] dout,
  input  wire logic        oe,
  input  wire logic        ext_rd,
  input  wire logic        ext_wr,
  // Bench control
  input  wire logic [7:0]  stall,
  // Answer
  output logic             ready,
  output logic [15:0]      din
);
  int          phases, len, last_len, drv_cnt, lat_cnt, bad, stall_c;
  logic [4:0]  last_cs;
  logic [28:0] last_addr;
  logic [15:0] last_wd;
  logic        last_rd;
  logic        act_d;
  wire logic   act = !rd_n || !wr_n;
  initial begin
    act_d = 1'b0;
    ready = 1'b1;
    din   = 16'h0000;
  end
  always @(posedge clk) begin
    act_d <= act;
    // Released bus flips every cycle
    din <= !rd_n ? (addr[15:0] ^ 16'h5a3c) : ~din;
    if (act && !act_d) begin
      phases    <= phases + 1;
      len       <= 1;
      last_cs   <= cs_n;
      last_addr <= addr;
      last_wd   <= dout;
      last_rd   <= !rd_n;
      stall_c   <= stall;
      ready     <= (stall == 8'h00);
    end else if (act) begin
      len     <= len + 1;
      stall_c <= (stall_c > 0) ? stall_c - 1 : 0;
      ready   <= (stall_c <= 1);
    end else begin
      ready <= 1'b1;
    end
    if (!act && act_d) last_len <= len;
    if (ext_wr) drv_cnt <= drv_cnt + 1;
    if (ext_rd) lat_cnt <= lat_cnt + 1;
    if (!rst && ((act && act_d && cs_n != last_cs) ||
        (!act && act_d && cs_n != 5'h1f) ||
        (!wr_n && !oe) || (!rd_n && (oe || !wr_n))))
      bad <= bad + 1;
  end
endmodule : io_partner
`default_nettype wire

// ==== test/pc_style_io_bus_cycles_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module pc_style_io_bus_cycles_tb;
  logic        clk = 0, rst = 1, ref_clk = 0, cpu_valid = 0;
  logic        cpu_write = 0, cpu_wide = 0, mux_latch = 0, mux_half = 0;
  logic [31:0] cpu_addr = 0, cpu_wdata = 0, a, d;
  logic [7:0]  stall = 0;
  wire logic        cpu_ready, rsp_valid, rd_n, wr_n, oe, rdy, ext_rd, ext_wr;
  wire logic [31:0] rsp_rdata;
  wire logic [28:0] ea;
  wire logic [4:0]  cs_n;
  wire logic [15:0] din, dout;
  int          mismatches, total_checks, r;
  logic [31:0] e;
  bit          saw_full;
  int          q_rd[$];
  logic [31:0] q_exp[$];
  always #2 clk = ~clk;
  always #16 ref_clk = ~ref_clk;
  pc_io_bus u_pc_io_bus (.clk(clk), .rst(rst), .io_reference_clock(ref_clk),
    .cpu_valid(cpu_valid), .cpu_ready(cpu_ready), .cpu_write(cpu_write),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wide(cpu_wide),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .exported_address_bus(ea), .cs_n(cs_n), .io_read_strobe(rd_n),
    .io_write_strobe(wr_n), .io_data_in(din), .io_data_out(dout),
    .io_data_oe(oe), .ready_pin(rdy), .ext_latch_rd(ext_rd),
    .ext_drive_wr(ext_wr), .mux_latch_in(mux_latch), .mux_half_in(mux_half));
  io_partner u_io_partner (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(ea), .dout(dout), .oe(oe), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .stall(stall), .ready(rdy), .din(din));
  task automatic chk_d(string n, logic [31:0] ex, logic [31:0] g);
    total_checks++;
    if (g !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, ex, g);
    end
  endtask : chk_d
  task automatic chk_r(string n, int lo, int hi, int g);
    total_checks++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chk_r
  function automatic int exp_len(logic [31:0] ad);
    logic [1:0] t;
    t = ad[20:19];
    if (ad[26:24] == 3'(pcio_pkg::LARGEST_AREA)) t[1] = 1'b0;
    case (t)
      2'h0: return 16 * int'(pcio_pkg::LEN_T0);
      2'h1: return 16 * int'(pcio_pkg::LEN_T1);
      2'h2: return 16 * int'(pcio_pkg::LEN_T2);
      default: return 16 * int'(pcio_pkg::LEN_T3);
    endcase
  endfunction : exp_len
  always @(posedge clk) begin
    if (cpu_ready === 1'b0) saw_full <= 1'b1;
    if (rsp_valid === 1'b1) begin
      if (q_rd.size() == 0) begin
        chk_d("spurious answer", 32'h0, 32'h1);
      end else begin
        r = q_rd.pop_front();
        e = q_exp.pop_front();
        if (r == 1)
          chk_d("read data", 32'(e[15:0]), 32'(rsp_rdata[15:0]));
        if (r == 2) chk_d("wide read data", e, rsp_rdata);
      end
    end
  end
  task automatic send(logic w, logic wd, logic [31:0] ad, logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    cpu_valid <= 1'b1;
    cpu_write <= w;
    cpu_wide  <= wd;
    cpu_addr  <= ad;
    cpu_wdata <= dt;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 5000);
    q_rd.push_back(w ? 0 : ((wd && (mux_half || mux_latch)) ? 2 : 1));
    q_exp.push_back({2{ad[15:0] ^ 16'h5a3c}});
    @(posedge clk);
    cpu_valid <= 1'b0;
  endtask : send
  task automatic drain;
    int n;
    n = 0;
    while (q_rd.size() > 0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    chk_r("answers pending", 0, 0, q_rd.size());
    repeat (2) @(posedge clk);
  endtask : drain
  task automatic one(logic w, logic wd, logic [31:0] ad, logic [31:0] dt);
    int p, dr, la, ph, l;
    p  = u_io_partner.phases;
    dr = u_io_partner.drv_cnt;
    la = u_io_partner.lat_cnt;
    ph = (wd && mux_half) ? 2 : 1;
    l  = exp_len(ad);
    send(w, wd, ad, dt);
    drain();
    chk_r("phases", ph, ph, u_io_partner.phases - p);
    chk_d("chip select", (ad[26:24] < 5) ? ~(32'h1 << ad[26:24]) & 32'h1f
          : 32'h1f, 32'(u_io_partner.last_cs));
    chk_d("address", 32'(ad[28:0]), 32'(u_io_partner.last_addr));
    chk_d("direction", 32'(!w), 32'(u_io_partner.last_rd));
    if (w) chk_d("write data", ph == 2 ? 32'(dt[31:16]) : 32'(dt[15:0]),
                 32'(u_io_partner.last_wd));
    if (stall > l) chk_r("stalled length", stall, stall + 24,
                         u_io_partner.last_len);
    else chk_r("length", l - 2, l + 2, u_io_partner.last_len);
    if (wd && !mux_half && !mux_latch)
      chk_r("extension", 1, 1 << 30, w ? u_io_partner.drv_cnt - dr
            : u_io_partner.lat_cnt - la);
    chk_r("strobe pairing", 0, 0, u_io_partner.bad);
  endtask : one
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    mismatches++;
    $display("wrong value watchdog expected done seen hang");
    summarize();
  end
  initial begin
    void'($urandom(32'hb8c2));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_d("reset outputs", 32'h7f, {25'h0, cs_n, rd_n, wr_n});
    chk_d("reset others", 32'h0, {oe, rsp_valid, ea});
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      a = $urandom();
      a[26:19] = {i[4:2], 3'h0, i[1:0]};
      d = $urandom();
      one(i[5], 1'b0, a, d);
    end
    $display("test areas done");
    @(posedge clk) stall <= 8'd200;
    for (int i = 0; i < 2; i++) one(i[0], 1'b0, 32'h0100_0000 | $urandom(), 0);
    @(posedge clk) stall <= 8'd0;
    $display("test stall done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      mux_half  <= i[1];
      mux_latch <= i[2];
      repeat (6) @(posedge clk);
      a = $urandom();
      a[26:24] = 3'h2;
      one(i[0], 1'b1, a, $urandom());
    end
    @(posedge clk) mux_half <= 1'b0;
    mux_latch <= 1'b0;
    $display("test wide done");
    saw_full = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = $urandom();
      a[26:24] = 3'($urandom_range(0, 4));
      send(i[0], 1'b0, a, $urandom());
    end
    drain();
    chk_d("queue refused", 32'h1, 32'(saw_full));
    $display("test burst done");
    summarize();
  end
endmodule : pc_style_io_bus_cycles_tb
`default_nettype wire
